// ===== rtl/gprf_pkg.sv
package gprf_pkg;

  // register index space: byte address = index * 4
  localparam int unsigned IDX_W        = 5;
  localparam logic [4:0] IDX_ACC       = 5'h00;
  localparam logic [4:0] IDX_CNT       = 5'h01;
  localparam logic [4:0] IDX_IOP       = 5'h02;
  localparam logic [4:0] IDX_BASE      = 5'h03;
  localparam logic [4:0] IDX_STK       = 5'h04;
  localparam logic [4:0] IDX_FRAME     = 5'h05;
  localparam logic [4:0] IDX_SRC       = 5'h06;
  localparam logic [4:0] IDX_DST       = 5'h07;
  localparam logic [4:0] IDX_SEG_EXTRA = 5'h08;
  localparam logic [4:0] IDX_SEG_CODE  = 5'h09;
  localparam logic [4:0] IDX_SEG_STACK = 5'h0a;
  localparam logic [4:0] IDX_SEG_MAIN  = 5'h0b;
  localparam logic [4:0] IDX_SEG_THIRD = 5'h0c;
  localparam logic [4:0] IDX_SEG_FOURTH= 5'h0d;
  localparam logic [4:0] IDX_MODE      = 5'h0e;
  localparam logic [4:0] IDX_IPTR      = 5'h0f;
  localparam logic [4:0] IDX_ALIAS16   = 5'h10;
  localparam logic [4:0] IDX_ALIAS8    = 5'h11;
  localparam logic [4:0] IDX_STATUS    = 5'h12;

  // mode register fields
  localparam int unsigned MODE_PROT_BIT = 0;
  localparam int unsigned MODE_D32_BIT  = 1;
  localparam logic [1:0]  MODE_RESET    = 2'h0;

  // alias registers: select field at [23:20], data in low bits
  localparam int unsigned ALIAS_SEL_LSB = 20;

  // address limits per default size
  localparam logic [31:0] LIMIT_32 = 32'hffffffff;
  localparam logic [31:0] LIMIT_16 = 32'h0000ffff;

  // implicit segment selection codes
  typedef enum logic [2:0] {
    GPRF_SEG_EXTRA  = 3'b000,
    GPRF_SEG_CODE   = 3'b001,
    GPRF_SEG_STACK  = 3'b010,
    GPRF_SEG_MAIN   = 3'b011,
    GPRF_SEG_THIRD  = 3'b100,
    GPRF_SEG_FOURTH = 3'b101
  } gprf_seg_e;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== rtl/gprf_size_ctl.sv
`timescale 1ns/1ns
// effective sizes: default from mode or code descriptor, per-instr prefix
module gprf_size_ctl (
  input  wire logic        prot_mode,
  input  wire logic        real_d32,
  input  wire logic        desc_d32,
  input  wire logic        addr_prefix,
  input  wire logic        opnd_prefix,
  output logic             addr32,
  output logic             opnd32,
  output logic [31:0]      off_limit
);
  logic dflt32;

  // protected mode takes the default from the code descriptor
  always_comb begin
    dflt32 = prot_mode ? desc_d32 : real_d32;
  end

  // a prefix flips the default for this instruction only
  always_comb begin
    addr32 = dflt32 ^ addr_prefix;
    opnd32 = dflt32 ^ opnd_prefix;
    off_limit = addr32 ? gprf_pkg::LIMIT_32 : gprf_pkg::LIMIT_16;
  end

endmodule

// ===== rtl/gprf_top.sv
`timescale 1ns/1ns
// Functional notes
// - 32-bit default: offsets to ffffffff, 32-bit operands
// - 16-bit default: offsets to ffff, 16-bit operands
// - far pointer: selector plus 32/16-bit offset
// - prefix overrides default sizes, one instruction
// - protected mode: default size from code descriptor
// - 16-bit alias maps onto low half
// - four registers expose high and low bytes
// - six 16-bit segment selector registers
// - fetch address is code selector plus pointer
// - code selector loads only on control transfer
// - stack operations use the stack selector
// - stack selector accepts explicit loads
// - string ops use count, source, destination
// - base/source use main, destination uses extra
// - stack and frame pointers use stack segment
// - six segments addressable, one per register
// - reset starts in real-address mode
module gprf_top (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  // axi4-lite slave
  input  wire logic [6:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [6:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // execute side
  input  wire logic        CODE_LOAD,
  input  wire logic [15:0] CODE_SEL_IN,
  input  wire logic [31:0] NEXT_IPTR,
  input  wire logic        DESC_D32,
  input  wire logic        ADDR_PREFIX,
  input  wire logic        OPND_PREFIX,
  output logic             ADDR32,
  output logic             OPND32,
  output logic [31:0]      OFFSET_LIMIT,
  output logic [15:0]      FETCH_SEL,
  output logic [31:0]      FETCH_OFF,
  output logic [15:0]      STACK_SEL,
  output logic [31:0]      STACK_OFF,
  output logic [31:0]      FRAME_OFF,
  output logic [31:0]      STR_COUNT,
  output logic [15:0]      STR_SRC_SEL,
  output logic [31:0]      STR_SRC_OFF,
  output logic [15:0]      STR_DST_SEL,
  output logic [31:0]      STR_DST_OFF,
  output logic [15:0]      BASE_SEL,
  output logic [31:0]      BASE_OFF
);

  logic [31:0] gpr [8];    // indexed by IDX_ACC..IDX_DST
  logic [15:0] seg [6];    // indexed by gprf_seg_e code
  logic [31:0] instr_pointer_reg;
  logic        prot_mode;
  logic        real_d32;
  logic        addr32;
  logic        opnd32;
  logic [31:0] off_limit;

  // write channel holding registers
  logic        aw_hold;
  logic        w_hold;
  logic [4:0]  aw_idx;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_bad;
  logic [31:0] wr_val;

  // alias write decode
  logic [2:0]  al_reg;
  logic        al_hi;

  gprf_size_ctl u_size (
    .prot_mode   (prot_mode),
    .real_d32    (real_d32),
    .desc_d32    (DESC_D32),
    .addr_prefix (ADDR_PREFIX),
    .opnd_prefix (OPND_PREFIX),
    .addr32      (addr32),
    .opnd32      (opnd32),
    .off_limit   (off_limit)
  );

  // accept address and data independently, in either order
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_idx  <= 5'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold <= 1'b1;
        aw_idx  <= S_AXI_AWADDR[6:2];
      end else if (wr_fire) begin
        aw_hold <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_hold <= 1'b0;
      end
    end
  end

  // ready only while the slot is empty and no response pending
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_hold && !(S_AXI_AWVALID && S_AXI_AWREADY)
                       && !S_AXI_BVALID && !wr_fire;
      S_AXI_WREADY  <= !w_hold && !(S_AXI_WVALID && S_AXI_WREADY)
                       && !S_AXI_BVALID && !wr_fire;
    end
  end

  // commit once both halves are held; a pending response stalls it
  assign wr_fire = aw_hold && w_hold && !S_AXI_BVALID;

  // code selector is read-only to software; unmapped indices error too
  always_comb begin
    wr_bad = (aw_idx == gprf_pkg::IDX_SEG_CODE)
             || (aw_idx == gprf_pkg::IDX_IPTR)
             || (aw_idx == gprf_pkg::IDX_STATUS)
             || (aw_idx > gprf_pkg::IDX_STATUS);
    // alias select rides in the data word, so no extra address decode
    al_reg = w_data[gprf_pkg::ALIAS_SEL_LSB +: 3];
    al_hi  = w_data[gprf_pkg::ALIAS_SEL_LSB + 3];
  end

  // write response
  // stays up until the master takes it
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= gprf_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_bad ? gprf_pkg::RESP_SLVERR : gprf_pkg::RESP_OKAY;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // byte-lane merge for full-width writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // general-purpose registers: word, 16-bit and byte alias writes
  // word writes honour byte strobes; alias writes ignore them
  generate
    for (genvar g = 0; g < 8; g++) begin : g_gpr
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          gpr[g] <= 32'h00000000;
        end else if (wr_fire && aw_idx == 5'(g)) begin
          gpr[g] <= merge(gpr[g], w_data, w_strb);
        end else if (wr_fire && aw_idx == gprf_pkg::IDX_ALIAS16
                     && al_reg == 3'(g)) begin
          gpr[g][15:0] <= w_data[15:0];
        end else if (wr_fire && aw_idx == gprf_pkg::IDX_ALIAS8
                     && al_reg == 3'(g) && g < 4) begin
          // byte aliases exist only for the first four registers
          if (al_hi) begin
            gpr[g][15:8] <= w_data[7:0];
          end else begin
            gpr[g][7:0] <= w_data[7:0];
          end
        end
      end
    end
  endgenerate

  // data and stack selectors load from software; code only on transfer
  generate
    for (genvar s = 0; s < 6; s++) begin : g_seg
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          seg[s] <= 16'h0000;
        end else if (s == 1) begin
          if (CODE_LOAD) begin
            seg[s] <= CODE_SEL_IN;
          end
        end else if (wr_fire
                     && aw_idx == gprf_pkg::IDX_SEG_EXTRA + 5'(s)) begin
          // selectors are 16 bits: only the two low byte lanes matter
          if (w_strb[0]) begin
            seg[s][7:0] <= w_data[7:0];
          end
          if (w_strb[1]) begin
            seg[s][15:8] <= w_data[15:8];
          end
        end
      end
    end
  endgenerate

  // mode: reset lands in real-address mode with 16-bit default
  // prefixes act on the size logic only; this register keeps the
  // default, so it returns after each prefixed instruction
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      prot_mode <= gprf_pkg::MODE_RESET[gprf_pkg::MODE_PROT_BIT];
      real_d32  <= gprf_pkg::MODE_RESET[gprf_pkg::MODE_D32_BIT];
    end else if (wr_fire && aw_idx == gprf_pkg::IDX_MODE
                 && w_strb[0]) begin
      prot_mode <= w_data[gprf_pkg::MODE_PROT_BIT];
      real_d32  <= w_data[gprf_pkg::MODE_D32_BIT];
    end
  end

  // pointer of next instruction tracks the execute side
  // no software write path: the execute side owns this value
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      instr_pointer_reg <= 32'h00000000;
    end else begin
      instr_pointer_reg <= NEXT_IPTR;
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= gprf_pkg::RESP_OKAY;
    end else begin
      // ready drops for at least two cycles after each accept, so at best one read in three cycles
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= gprf_pkg::RESP_OKAY;
        unique case (S_AXI_ARADDR[6:2])
          gprf_pkg::IDX_ACC, gprf_pkg::IDX_CNT, gprf_pkg::IDX_IOP,
          gprf_pkg::IDX_BASE, gprf_pkg::IDX_STK, gprf_pkg::IDX_FRAME,
          gprf_pkg::IDX_SRC, gprf_pkg::IDX_DST:
            S_AXI_RDATA <= gpr[S_AXI_ARADDR[4:2]];
          gprf_pkg::IDX_SEG_EXTRA, gprf_pkg::IDX_SEG_CODE,
          gprf_pkg::IDX_SEG_STACK, gprf_pkg::IDX_SEG_MAIN,
          gprf_pkg::IDX_SEG_THIRD, gprf_pkg::IDX_SEG_FOURTH:
            S_AXI_RDATA <= {16'h0000,
                            seg[3'(S_AXI_ARADDR[6:2] - 5'h08)]};
          gprf_pkg::IDX_MODE:
            S_AXI_RDATA <= {30'h00000000, real_d32, prot_mode};
          gprf_pkg::IDX_IPTR:
            S_AXI_RDATA <= instr_pointer_reg;
          gprf_pkg::IDX_STATUS:
            S_AXI_RDATA <= {30'h00000000, opnd32, addr32};
          default: begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= gprf_pkg::RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // size outputs registered from the combinational size logic
  // same timing as the masked offsets, so limit and offsets agree
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ADDR32       <= 1'b0;
      OPND32       <= 1'b0;
      OFFSET_LIMIT <= gprf_pkg::LIMIT_16;
    end else begin
      ADDR32       <= addr32;
      OPND32       <= opnd32;
      OFFSET_LIMIT <= off_limit;
    end
  end

  // implicit operand sources; offsets truncated to the address size
  // all lag state by one cycle; consumers must allow for that
  // delay rather than bypass it
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      FETCH_SEL   <= 16'h0000;
      FETCH_OFF   <= 32'h00000000;
      STACK_SEL   <= 16'h0000;
      STACK_OFF   <= 32'h00000000;
      FRAME_OFF   <= 32'h00000000;
      STR_COUNT   <= 32'h00000000;
      STR_SRC_SEL <= 16'h0000;
      STR_SRC_OFF <= 32'h00000000;
      STR_DST_SEL <= 16'h0000;
      STR_DST_OFF <= 32'h00000000;
      BASE_SEL    <= 16'h0000;
      BASE_OFF    <= 32'h00000000;
    end else begin
      FETCH_SEL   <= seg[gprf_pkg::GPRF_SEG_CODE];
      FETCH_OFF   <= instr_pointer_reg & off_limit;
      STACK_SEL   <= seg[gprf_pkg::GPRF_SEG_STACK];
      STACK_OFF   <= gpr[gprf_pkg::IDX_STK[2:0]] & off_limit;
      FRAME_OFF   <= gpr[gprf_pkg::IDX_FRAME[2:0]] & off_limit;
      STR_COUNT   <= gpr[gprf_pkg::IDX_CNT[2:0]]
                     & (opnd32 ? gprf_pkg::LIMIT_32
                               : gprf_pkg::LIMIT_16);
      STR_SRC_SEL <= seg[gprf_pkg::GPRF_SEG_MAIN];
      STR_SRC_OFF <= gpr[gprf_pkg::IDX_SRC[2:0]] & off_limit;
      STR_DST_SEL <= seg[gprf_pkg::GPRF_SEG_EXTRA];
      STR_DST_OFF <= gpr[gprf_pkg::IDX_DST[2:0]] & off_limit;
      BASE_SEL    <= seg[gprf_pkg::GPRF_SEG_MAIN];
      BASE_OFF    <= gpr[gprf_pkg::IDX_BASE[2:0]] & off_limit;
    end
  end

endmodule

// ===== sim/gprf_monitor.sv
`timescale 1ns/1ns
// watches handshake timing, size limits and the fetch pointer
module gprf_monitor (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        CODE_LOAD,
  input wire logic [31:0] NEXT_IPTR,
  input wire logic [15:0] FETCH_SEL,
  input wire logic [31:0] FETCH_OFF,
  input wire logic        ADDR32,
  input wire logic [31:0] OFFSET_LIMIT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // limit must track the effective address size
  property p_lim32; ADDR32 |-> OFFSET_LIMIT == 32'hffffffff; endproperty
  a_lim32: assert property (p_lim32)
    else $error("limit not 32-bit");
  property p_lim16; !ADDR32 |-> OFFSET_LIMIT == 32'h0000ffff; endproperty
  a_lim16: assert property (p_lim16)
    else $error("limit not 16-bit");
  // settled pointer appears masked by the limit
  property p_fetch;
    ($stable(NEXT_IPTR) && $stable(ADDR32))[*3]
      |-> FETCH_OFF == (NEXT_IPTR & OFFSET_LIMIT);
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch offset wrong");
  // a bus write must never move the code selector
  property p_cs_hold;
    $changed(FETCH_SEL) |-> $past(CODE_LOAD) || $past(CODE_LOAD, 2);
  endproperty
  a_cs_hold: assert property (p_cs_hold)
    else $error("code sel moved");
  property p_bresp;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##2 S_AXI_BVALID;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");
  property p_rresp; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read response late");
  property p_bhold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule
bind gprf_top gprf_monitor gprf_monitor_i (.CLOCK, .RST_N, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY,
  .S_AXI_RDATA, .CODE_LOAD, .NEXT_IPTR, .FETCH_SEL, .FETCH_OFF, .ADDR32,
  .OFFSET_LIMIT);

// ===== sim/gprf_exec_model.sv
`timescale 1ns/1ns
// stands in for decode/execute: control transfers and size controls
module gprf_exec_model (
  input  wire logic        CLOCK,
  output logic             CODE_LOAD,
  output logic [15:0]      CODE_SEL_IN,
  output logic [31:0]      NEXT_IPTR,
  output logic             DESC_D32,
  output logic             ADDR_PREFIX,
  output logic             OPND_PREFIX
);
  // idle values before the first edge
  initial begin
    CODE_LOAD = 1'b0;
    CODE_SEL_IN = 16'h0000;
    NEXT_IPTR = 32'h00000000;
    DESC_D32 = 1'b0;
    ADDR_PREFIX = 1'b0;
    OPND_PREFIX = 1'b0;
  end
  // selector is only meaningful during the one-cycle load pulse
  task automatic jump(input logic [15:0] s, input logic [31:0] ip);
    @(posedge CLOCK);
    CODE_LOAD <= 1'b1;
    CODE_SEL_IN <= s;
    NEXT_IPTR <= ip;
    @(posedge CLOCK);
    CODE_LOAD <= 1'b0;
    CODE_SEL_IN <= ~s; // stale value must not be captured
  endtask
  // descriptor size and per-instruction prefixes
  task automatic cfg(input logic d, input logic a, input logic o);
    @(posedge CLOCK);
    DESC_D32 <= d;
    ADDR_PREFIX <= a;
    OPND_PREFIX <= o;
  endtask
endmodule

// ===== sim/gprf_tb_top.sv
`timescale 1ns/1ns
module gprf_tb_top;
  logic CLOCK = 0, RST_N = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0;
  logic S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic [6:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [3:0] S_AXI_WSTRB = 0;
  logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, NEXT_IPTR, FETCH_OFF, STACK_OFF;
  logic [31:0] FRAME_OFF, STR_COUNT, STR_SRC_OFF, STR_DST_OFF, BASE_OFF;
  logic [31:0] OFFSET_LIMIT;
  logic [15:0] CODE_SEL_IN, FETCH_SEL, STACK_SEL, STR_SRC_SEL, STR_DST_SEL;
  logic [15:0] BASE_SEL;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, CODE_LOAD, DESC_D32, ADDR_PREFIX, OPND_PREFIX;
  logic ADDR32, OPND32;
  logic [31:0] r [8];
  int num_errors = 0;
  int compares = 0;
  always #5 CLOCK = ~CLOCK;
  gprf_top gprf_top_i (.CLOCK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .CODE_LOAD, .CODE_SEL_IN, .NEXT_IPTR, .DESC_D32, .ADDR_PREFIX,
    .OPND_PREFIX, .ADDR32, .OPND32, .OFFSET_LIMIT, .FETCH_SEL, .FETCH_OFF,
    .STACK_SEL, .STACK_OFF, .FRAME_OFF, .STR_COUNT, .STR_SRC_SEL,
    .STR_SRC_OFF, .STR_DST_SEL, .STR_DST_OFF, .BASE_SEL, .BASE_OFF);
  gprf_exec_model gprf_exec_model_i (.CLOCK, .CODE_LOAD, .CODE_SEL_IN,
    .NEXT_IPTR, .DESC_D32, .ADDR_PREFIX, .OPND_PREFIX);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [6:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] e);
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= s;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    chk({30'h0, S_AXI_BRESP}, {30'h0, e});
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    chk(S_AXI_RDATA, d);
    chk({30'h0, S_AXI_RRESP}, {30'h0, e});
  endtask
  // implicit register outputs under given address and operand masks
  task automatic xchk(input logic [31:0] am, input logic [31:0] om);
    repeat (3) @(posedge CLOCK);
    chk(STR_COUNT, r[1] & om);
    chk({16'h0, STR_SRC_SEL}, 32'h0000a00b);
    chk(STR_SRC_OFF, r[6] & am);
    chk({16'h0, STR_DST_SEL}, 32'h0000a008);
    chk(STR_DST_OFF, r[7] & am);
    chk({16'h0, BASE_SEL}, 32'h0000a00b);
    chk(BASE_OFF, r[3] & am);
    chk({16'h0, STACK_SEL}, 32'h0000a00a);
    chk(STACK_OFF, r[4] & am);
    chk(FRAME_OFF, r[5] & am);
    chk(OFFSET_LIMIT, am);
    chk({31'h0, ADDR32}, {31'h0, am[16]});
    chk({31'h0, OPND32}, {31'h0, om[16]});
  endtask
  task automatic finish_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // run is a few hundred cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge CLOCK);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'b1;
    // alias slots are write-only and answer reads with an error
    for (int i = 0; i < 19; i++) begin
      rd(7'(i * 4), 32'h0, (i inside {16, 17}) ? 2'h2 : 2'h0);
    end
    chk(OFFSET_LIMIT, 32'h0000ffff);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      r[i] = 32'h11111111 * (i + 1);
      wr(7'(i * 4), r[i], 4'hf, 2'h0);
      rd(7'(i * 4), r[i], 2'h0);
    end
    // code selector refuses bus writes, the others keep 16 bits
    for (int j = 8; j < 14; j++) begin
      wr(7'(j * 4), {16'hffff, 16'ha000 + 16'(j)}, 4'hf,
         j == 9 ? 2'h2 : 2'h0);
      rd(7'(j * 4), j == 9 ? 32'h0 : {16'h0, 16'ha000 + 16'(j)},
         2'h0);
    end
    wr(7'h3c, 32'h1, 4'hf, 2'h2);
    wr(7'h4c, 32'h1, 4'hf, 2'h2);
    rd(7'h4c, 32'h0, 2'h2);
    $display("test registers done");
    xchk(32'h0000ffff, 32'h0000ffff);
    wr(7'h38, 32'h2, 4'hf, 2'h0);
    xchk(32'hffffffff, 32'hffffffff);
    rd(7'h48, 32'h3, 2'h0);
    gprf_exec_model_i.cfg(1'b0, 1'b1, 1'b0);
    xchk(32'h0000ffff, 32'hffffffff);
    gprf_exec_model_i.cfg(1'b0, 1'b0, 1'b1);
    xchk(32'hffffffff, 32'h0000ffff);
    gprf_exec_model_i.cfg(1'b0, 1'b0, 1'b0);
    wr(7'h38, 32'h1, 4'hf, 2'h0);
    xchk(32'h0000ffff, 32'h0000ffff);
    gprf_exec_model_i.cfg(1'b1, 1'b0, 1'b0);
    xchk(32'hffffffff, 32'hffffffff);
    gprf_exec_model_i.jump(16'h7c01, 32'hdead0123);
    repeat (3) @(posedge CLOCK);
    chk({16'h0, FETCH_SEL}, 32'h00007c01);
    chk(FETCH_OFF, 32'hdead0123);
    wr(7'h38, 32'h0, 4'hf, 2'h0);
    gprf_exec_model_i.jump(16'h7c02, 32'h00123456);
    repeat (3) @(posedge CLOCK);
    chk(FETCH_OFF, 32'h00003456);
    rd(7'h24, 32'h00007c02, 2'h0);
    $display("test sizes done");
    // alias writes touch only their bits; strobes are ignored there
    for (int i = 0; i < 8; i++) begin
      r[i][15:0] = 16'hc0d0 + 16'(i);
      wr(7'h40, {9'h0, 3'(i), 4'h0, r[i][15:0]}, 4'h0, 2'h0);
      rd(7'(i * 4), r[i], 2'h0);
    end
    for (int i = 0; i < 4; i++) begin
      r[i][15:8] = 8'he0 + 8'(i);
      r[i][7:0] = 8'hf0 + 8'(i);
      wr(7'h44, {8'h0, 1'b1, 3'(i), 12'h0, r[i][15:8]}, 4'hf, 2'h0);
      wr(7'h44, {8'h0, 1'b0, 3'(i), 12'h0, r[i][7:0]}, 4'hf, 2'h0);
      rd(7'(i * 4), r[i], 2'h0);
    end
    $display("test aliases done");
    finish_test();
  end
endmodule
